// ==== src/pssr_map.vh ====
// Register offsets, field positions and reset values of the slot status and cap2 bank
`ifndef PSSR_MAP_VH
`define PSSR_MAP_VH

// ============================================================
// Offsets (byte addresses)
`define PSSR_OFF_SLOT 8'hd8
`define PSSR_OFF_DCAP2 8'he4
`define PSSR_OFF_DCTL2 8'he8
`define PSSR_OFF_LCAP2 8'hec
`define PSSR_OFF_LCTL2 8'hf0
`define PSSR_OFF_SCAP2 8'hf4
`define PSSR_OFF_SCTL2 8'hf8
`define PSSR_OFF_INTST 8'hfc
`define PSSR_OFF_INTMSK 12'h100
`define PSSR_OFF_SLCTL 12'h104

// ============================================================
// Slot status bits
`define PSSR_B_ABP 16
`define PSSR_B_PFD 17
`define PSSR_B_MSC 18
`define PSSR_B_PDC 19
`define PSSR_B_CC 20
`define PSSR_B_MSS 21
`define PSSR_B_PDS 22
`define PSSR_B_DLLSC 24

// ============================================================
// Slot control enables (own register)
`define PSSR_B_ABP_EN 0
`define PSSR_B_PFD_EN 1
`define PSSR_B_PDC_EN 3
`define PSSR_B_CC_EN 4
`define PSSR_B_HPI_EN 5

// ============================================================
// Capabilities and controls
`define PSSR_B_LTR_SUP 11
`define PSSR_DCAP2_VAL 32'h0004_0800
`define PSSR_B_LTR_EN 10
`define PSSR_B_OBFF_LO 13
`define PSSR_DCTL2_WMASK 32'h0000_6400
`define PSSR_LCTL2_WMASK 32'h0000_1fbf
`define PSSR_LCTL2_RST 32'h0000_0002
`define PSSR_B_DEEMP 6
`define PSSR_RST_DLLSC 1'b1

`endif

// ==== src/pssr_sync.v ====
// Two flip-flop synchroniser for a group of pin levels
`timescale 1ns/10ps
module pssr_sync #(
    parameter WIDTH = 4
) (
    // Clock and reset
    input wire clk_sys_i,
    input wire rst_n_i,
    // Levels
    input wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    always @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_r <= {WIDTH{1'b0}};
            sync_r <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;
endmodule // pssr_sync

// ==== src/pssr_evt.v ====
// Sticky write-one-to-clear flag bank, hardware set beats software clear
`timescale 1ns/10ps
module pssr_evt #(
    parameter WIDTH = 5,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    // Clock and reset
    input wire clk_sys_i,
    input wire rst_n_i,
    // Set and clear
    input wire [WIDTH-1:0] set_i,
    input wire [WIDTH-1:0] clr_i,
    output wire [WIDTH-1:0] flag_o
);
    reg [WIDTH-1:0] flag_r;
    genvar g;

    generate
        for (g = 0; g < WIDTH; g = g + 1)
        begin : g_flag
            always @(posedge clk_sys_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                    flag_r[g] <= RST_VAL[g];
                else if (set_i[g])
                    flag_r[g] <= 1'b1;
                else if (clr_i[g])
                    flag_r[g] <= 1'b0;
            end
        end
    endgenerate

    assign flag_o = flag_r;
endmodule // pssr_evt

// ==== src/pssr_regs.v ====
// Slot status and second-generation capability/control register bank, APB slave
//
// What this block does
// - Attention button press sets bit 16, W1C
// - Power fault sets bit 17, W1C
// - Latch sensor change flag bit 18, read-only
// - Presence change sets bit 19, W1C
// - Command completion sets bit 20, W1C
// - Bit 21 shows latch sensor, open is one
// - Bit 22 shows card presence
// - No slot implemented: presence reads one
// - Presence resets to inverse of strap
// - Link-active change sets W1C bit 24, resets one
// - Capability bits 11 and 18 read one, others zero
// - Capability bits 19:18 read binary 01
// - Control bit 10 and bits 14:13 read-write
// - De-emphasis bit resets by port direction
// - Hot-plug interrupt only when matching enable set
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
`include "pssr_map.vh"
module pssr_regs #(
    parameter DOWNSTREAM = 1,
    parameter SLOT_IMPL = 1
) (
    // Clock and reset
    input wire clk_sys_i,
    input wire rst_n_i,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire pslverr,
    output reg [31:0] prdata,
    // Slot pins
    input wire attn_button_i,
    input wire power_fault_i,
    input wire latch_open_i,
    input wire card_present_i,
    input wire presence_strap_i,
    // Same-clock events
    input wire cmd_done_i,
    input wire link_active_i,
    // Outputs
    output wire hp_irq_o,
    output wire irq_o,
    output wire ltr_en_o,
    output wire [1:0] obff_en_o,
    output wire [15:0] link_ctl2_o
);
    // ============================================================
    // Pin synchronisers
    wire [4:0] pin_s;
    pssr_sync #(
        .WIDTH(5)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .async_i({presence_strap_i, card_present_i, latch_open_i, power_fault_i,
            attn_button_i}),
        .sync_o(pin_s)
    );
    wire btn_s = pin_s[0];
    wire pf_s = pin_s[1];
    wire latch_s = pin_s[2];
    wire card_s = pin_s[3];
    wire strap_s = pin_s[4];

    // ============================================================
    // APB decode
    wire wr_acc = psel && penable && pwrite;
    wire rd_acc = psel && penable && !pwrite;
    wire hit_slot = (paddr == {4'h0, `PSSR_OFF_SLOT});
    wire hit_dctl2 = (paddr == {4'h0, `PSSR_OFF_DCTL2});
    wire hit_lctl2 = (paddr == {4'h0, `PSSR_OFF_LCTL2});
    wire hit_intst = (paddr == {4'h0, `PSSR_OFF_INTST});
    wire hit_intmsk = (paddr == `PSSR_OFF_INTMSK);
    wire hit_slctl = (paddr == `PSSR_OFF_SLCTL);
    wire hit_ro = (paddr == {4'h0, `PSSR_OFF_DCAP2}) || (paddr == {4'h0, `PSSR_OFF_LCAP2})
        || (paddr == {4'h0, `PSSR_OFF_SCAP2}) || (paddr == {4'h0, `PSSR_OFF_SCTL2});
    wire mapped = hit_slot || hit_dctl2 || hit_lctl2 || hit_intst || hit_intmsk
        || hit_slctl || hit_ro;

    // Zero-wait slave; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // ============================================================
    // Edge detection and strap capture
    reg btn_d_r;
    reg pf_d_r;
    reg latch_d_r;
    reg card_d_r;
    reg link_d_r;
    reg init_r;
    reg init2_r;
    always @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            btn_d_r <= 1'b0;
            pf_d_r <= 1'b0;
            latch_d_r <= 1'b0;
            card_d_r <= 1'b0;
            link_d_r <= 1'b0;
            init_r <= 1'b0;
            init2_r <= 1'b0;
        end
        else
        begin
            btn_d_r <= btn_s;
            pf_d_r <= pf_s;
            latch_d_r <= latch_s;
            card_d_r <= card_s;
            link_d_r <= link_active_i;
            init_r <= 1'b1;
            // Synchronisers hold true pin levels from the second edge on
            init2_r <= init_r;
        end
    end

    // Presence state before first presence change is the inverse of the strap
    reg strap_done_r;
    reg strap_pds_r;
    always @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            strap_done_r <= 1'b0;
            strap_pds_r <= 1'b0;
        end
        else if (!strap_done_r && init2_r)
        begin
            strap_done_r <= 1'b1;
            strap_pds_r <= !strap_s;
        end
    end

    // ============================================================
    // Event flags
    // Pin edges ignored until synchronisers are full, else reset fakes an edge
    wire ev_abp = btn_s && !btn_d_r && strap_done_r;
    wire ev_pfd = pf_s && !pf_d_r && strap_done_r;
    wire ev_msc = (latch_s != latch_d_r) && strap_done_r;
    wire ev_pdc = (card_s != card_d_r) && strap_done_r;
    wire ev_cc = cmd_done_i;
    wire ev_dll = (link_active_i != link_d_r) && init_r;

    wire slot_wr = wr_acc && hit_slot;
    wire [4:0] w1c = slot_wr ? {pwdata[`PSSR_B_DLLSC], pwdata[`PSSR_B_CC],
        pwdata[`PSSR_B_PDC], pwdata[`PSSR_B_PFD], pwdata[`PSSR_B_ABP]} : 5'h00;
    wire [4:0] w1c_flag;
    pssr_evt #(
        .WIDTH(5),
        .RST_VAL(5'h10)
    ) u_w1c (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .set_i({ev_dll, ev_cc, ev_pdc, ev_pfd, ev_abp}),
        .clr_i(w1c),
        .flag_o(w1c_flag)
    );

    // Latch changed flag: software cannot clear it, only reset does
    reg msc_r;
    always @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            msc_r <= 1'b0;
        else if (ev_msc)
            msc_r <= 1'b1;
    end

    reg pds_r_valid;
    always @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pds_r_valid <= 1'b0;
        else if (ev_pdc)
            pds_r_valid <= 1'b1;
    end
    wire pres_state = (SLOT_IMPL == 0) ? 1'b1 : pds_r_valid ? card_s
        : strap_pds_r;

    wire [31:0] slot_rd;
    assign slot_rd = {7'h00, w1c_flag[4], 1'b0, pres_state, latch_s, w1c_flag[3],
        w1c_flag[2], msc_r, w1c_flag[1], w1c_flag[0], 16'h0000};

    // ============================================================
    // Writable control registers
    reg [31:0] dctl2_r;
    reg [31:0] lctl2_r;
    reg [5:0] slctl_r;
    reg [5:0] intmsk_r;
    always @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            dctl2_r <= 32'h0000_0000;
            lctl2_r <= `PSSR_LCTL2_RST;
            slctl_r <= 6'h00;
            intmsk_r <= 6'h00;
        end
        else
        begin
            if (wr_acc && hit_dctl2)
                dctl2_r <= pwdata & `PSSR_DCTL2_WMASK;
            if (wr_acc && hit_lctl2)
                lctl2_r <= pwdata & `PSSR_LCTL2_WMASK;
            if (wr_acc && hit_slctl)
                slctl_r <= pwdata[5:0];
            if (wr_acc && hit_intmsk)
                intmsk_r <= pwdata[5:0];
        end
    end
    wire deemp = (DOWNSTREAM != 0);
    wire [31:0] lctl2_rd = {lctl2_r[31:7], deemp, lctl2_r[5:0]};

    assign ltr_en_o = dctl2_r[`PSSR_B_LTR_EN];
    assign obff_en_o = dctl2_r[14:13];
    assign link_ctl2_o = lctl2_rd[15:0];

    // ============================================================
    // Hot-plug interrupt gating
    wire hp_any = (w1c_flag[0] && slctl_r[`PSSR_B_ABP_EN])
        || (w1c_flag[1] && slctl_r[`PSSR_B_PFD_EN])
        || (w1c_flag[2] && slctl_r[`PSSR_B_PDC_EN])
        || (w1c_flag[3] && slctl_r[`PSSR_B_CC_EN]);
    assign hp_irq_o = hp_any && slctl_r[`PSSR_B_HPI_EN];

    // ============================================================
    // Interrupt status: sticky, cleared by a read, set wins
    reg [5:0] intst_r;
    wire [5:0] int_ev = {ev_dll, ev_msc, ev_cc, ev_pdc, ev_pfd, ev_abp};
    wire intst_rd = rd_acc && hit_intst;
    always @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            intst_r <= 6'h00;
        else
            intst_r <= int_ev | (intst_rd ? 6'h00 : intst_r);
    end
    assign irq_o = |(intst_r & intmsk_r);

    // ============================================================
    // Read mux
    always @*
    begin
        prdata = 32'h0000_0000;
        if (rd_acc)
        begin
            case (paddr)
                {4'h0, `PSSR_OFF_SLOT}: prdata = slot_rd;
                {4'h0, `PSSR_OFF_DCAP2}: prdata = `PSSR_DCAP2_VAL;
                {4'h0, `PSSR_OFF_DCTL2}: prdata = dctl2_r;
                {4'h0, `PSSR_OFF_LCTL2}: prdata = lctl2_rd;
                {4'h0, `PSSR_OFF_INTST}: prdata = {26'h0000000, intst_r};
                `PSSR_OFF_INTMSK: prdata = {26'h0000000, intmsk_r};
                `PSSR_OFF_SLCTL: prdata = {26'h0000000, slctl_r};
                default: prdata = 32'h0000_0000;
            endcase
        end
    end
endmodule // pssr_regs

// ==== test/pssr_slot_model.sv ====
// Hot-plug slot model driving the slot pins
`timescale 1ns/10ps
module pssr_slot_model (
    // Clock
    input wire logic clk_sys_i,
    // Requested levels: card, latch, fault, button
    input wire logic [3:0] lvl_i,
    // Slot pins
    output logic attn_button_o,
    output logic power_fault_o,
    output logic latch_open_o,
    output logic card_present_o
);
    // Pins settle one cycle after a request, no bounce modelled
    always @(posedge clk_sys_i)
        {card_present_o, latch_open_o, power_fault_o, attn_button_o} <= lvl_i;
endmodule // pssr_slot_model

// ==== test/pssr_regs_assertions.sv ====
// Checker of the bank's APB answers and control outputs
`timescale 1ns/10ps
module pssr_regs_assertions #(
    parameter DOWNSTREAM = 1
) (
    // Clock and reset
    input wire clk_sys_i,
    input wire rst_n_i,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire [31:0] prdata,
    // Controls
    input wire ltr_en_o,
    input wire [1:0] obff_en_o,
    input wire [15:0] link_ctl2_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);
    wire rd_w = psel && penable && !pwrite;
    wire wr_w = psel && penable && pwrite;
    wire map_w = paddr[1:0] == 2'h0 && paddr >= 12'hd8 && paddr <= 12'h104
        && paddr != 12'hdc && paddr != 12'he0;
    sequence s_wr(a);
        wr_w && paddr == a;
    endsequence
    AST_ZERO_WAIT: assert property (psel && penable |-> pready)
        else $error("access not answered at once");
    AST_SLVERR: assert property (psel && penable |-> pslverr == !map_w)
        else $error("error response wrong");
    AST_RD_IDLE: assert property (!rd_w |-> prdata == 32'h0)
        else $error("read data outside read");
    AST_DCAP2: assert property (rd_w && paddr == 12'he4 |-> prdata == 32'h0004_0800)
        else $error("capability word wrong");
    AST_LTR_WR: assert property (s_wr(12'he8) |=> ltr_en_o == $past(pwdata[10]))
        else $error("latency enable not written");
    AST_OBFF_WR: assert property (s_wr(12'he8) |=> obff_en_o == $past(pwdata[14:13]))
        else $error("flush enable not written");
    AST_DEEMP: assert property (link_ctl2_o[6] == DOWNSTREAM[0] && link_ctl2_o[15:13] == 3'h0)
        else $error("link control fixed bits wrong");
    AST_RO_ZERO: assert property (rd_w && paddr inside {12'hec, 12'hf4, 12'hf8} |-> prdata == 0)
        else $error("zero word not zero");
endmodule // pssr_regs_assertions
bind pssr_regs pssr_regs_assertions #(.DOWNSTREAM(DOWNSTREAM)) chk_u (.clk_sys_i, .rst_n_i,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .ltr_en_o,
    .obff_en_o, .link_ctl2_o);

// ==== test/testbench.sv ====
// Self-checking bench of the slot status and cap2 bank
`timescale 1ns/10ps
module testbench;
    // ========
    // Signals
    logic clk_sys_i = 0;
    logic rst_n_i = 0;
    logic psel = 0, penable = 0, pwrite = 0, cmd_done_i = 0, link_active_i = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, hp_irq_o, irq_o, ltr_en_o, ab, pf, lo, cp, err;
    logic [1:0] obff_en_o;
    logic [15:0] link_ctl2_o;
    logic [3:0] lvl = 0;
    logic strap = 0;
    int n_errors = 0, check_count = 0, cyc = 0;
    logic [11:0] ra [7] = '{12'hd8, 12'he4, 12'he8, 12'hec, 12'hf0, 12'hf4, 12'hf8};
    logic [31:0] re [7] = '{32'h0140_0000, 32'h0004_0800, 0, 0, 32'h42, 0, 0};
    logic [11:0] ta [5] = '{12'he8, 12'hf0, 12'he4, 12'hf8, 12'h0c0};
    logic [31:0] te [5] = '{32'h6400, 32'h1fff, 32'h0004_0800, 0, 0};
    pssr_slot_model slot_u (.clk_sys_i, .lvl_i(lvl), .attn_button_o(ab), .power_fault_o(pf),
        .latch_open_o(lo), .card_present_o(cp));
    pssr_regs dut_u (.clk_sys_i, .rst_n_i, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .pslverr, .prdata, .attn_button_i(ab), .power_fault_i(pf), .latch_open_i(lo),
        .card_present_i(cp), .presence_strap_i(strap), .cmd_done_i, .link_active_i, .hp_irq_o,
        .irq_o, .ltr_en_o, .obff_en_o, .link_ctl2_o);
    initial forever #5 clk_sys_i = ~clk_sys_i;
    // ========
    // Tasks
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1;
        do @(posedge clk_sys_i); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 0);
        chk($sformatf("reg %h", a), e, rd);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Generous ceiling, the sequence needs under two hundred cycles
    always @(posedge clk_sys_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_errors++;
            give_verdict();
        end
    end
    // ========
    // Sequence
    initial
    begin
        wt(12);
        rst_n_i <= 1;
        wt(4);
        foreach (ra[i])
            rc(ra[i], re[i]);
        apb(0, 12'hfc, 0);
        apb(1, 12'hd8, 0);
        rc(12'hd8, 32'h0140_0000);
        apb(1, 12'hd8, 32'h0100_0000);
        rc(12'hd8, 32'h0040_0000);
        link_active_i <= 1;
        wt(8);
        rc(12'hd8, 32'h0140_0000);
        apb(1, 12'h100, 1);
        apb(1, 12'h104, 1);
        lvl <= 4'b0001;
        wt(8);
        rc(12'hd8, 32'h0141_0000);
        chk("hp_irq", 0, hp_irq_o);
        chk("irq", 1, irq_o);
        apb(1, 12'h104, 32'h21);
        wt(2);
        chk("hp_irq", 1, hp_irq_o);
        rc(12'hfc, 32'h21);
        wt(2);
        chk("irq", 0, irq_o);
        apb(1, 12'hd8, 32'h0001_0000);
        wt(2);
        chk("hp_irq", 0, hp_irq_o);
        lvl <= 4'b1111;
        wt(8);
        rc(12'hd8, 32'h016e_0000);
        chk("hp_irq", 0, hp_irq_o);
        apb(1, 12'hd8, 32'h017f_0000);
        rc(12'hd8, 32'h0064_0000);
        // Completion lands in the very cycle of its clearing write
        fork
            apb(1, 12'hd8, 32'h0010_0000);
            begin
                wt(2);
                cmd_done_i <= 1;
                wt(1);
                cmd_done_i <= 0;
            end
        join
        rc(12'hd8, 32'h0074_0000);
        apb(1, 12'hd8, 32'h0010_0000);
        rc(12'hd8, 32'h0064_0000);
        foreach (ta[i])
        begin
            apb(1, ta[i], '1);
            rc(ta[i], te[i]);
        end
        chk("slverr", 1, err);
        chk("ltr", 1, ltr_en_o);
        chk("obff", 3, obff_en_o);
        // Second reset with strap high and every pin already high
        strap <= 1;
        rst_n_i <= 0;
        wt(2);
        rst_n_i <= 1;
        wt(4);
        rc(12'hd8, 32'h0120_0000);
        chk("ltr", 0, ltr_en_o);
        give_verdict();
    end
endmodule // testbench
